// ### instrument_bus_host_port.sv
// Purpose: Bus talker and listener port plus serial line front end.
// Assumes: Inputs synchronous to sys_clk; bus lines in logical sense.
// Notes: Received listener bytes pass a small FIFO toward the parser.
`timescale 1ns/1ps

// ----------------
// Small FIFO with valid and ready on both sides.
// ----------------
module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Fill side.
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side.
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
      $error("Bad FIFO depth.");
    end
  endgenerate
  logic [WIDTH-1:0] mem [DEPTH]; // Storage words.
  logic [AW-1:0] wr_reg; // Write pointer.
  logic [AW-1:0] rd_reg; // Read pointer.
  logic [AW:0] cnt_reg; // Words held.
  logic push;
  logic pop;
  assign in_ready = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // Pointers move on every accepted word; the count holds when a push and a pop coincide.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        mem[wr_reg] <= in_data;
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : byte_fifo

// ----------------
// Top level.
// ----------------
module instrument_bus_host_port
  import instrument_bus_pkg::*;
#(
  parameter int LINE_DEPTH = 128
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Bus data lines.
  input wire logic [7:0] dio_in,
  output logic [7:0] dio_out,
  output logic dio_oe,
  // Bus handshake and management lines.
  input wire logic dav_in,
  output logic dav_out,
  output logic dav_oe,
  input wire logic nrfd_in,
  output logic nrfd_out,
  output logic nrfd_oe,
  input wire logic ndac_in,
  output logic ndac_out,
  output logic ndac_oe,
  input wire logic eoi_in,
  output logic eoi_out,
  output logic eoi_oe,
  input wire logic atn_in,
  input wire logic ifc_in,
  output logic srq_out,
  output logic srq_oe,
  // Talker data source.
  input wire logic src_valid,
  input wire logic [7:0] src_data,
  input wire logic src_end,
  output logic src_done,
  // Listener data toward the parser.
  output logic lst_valid,
  output logic [8:0] lst_data,
  input wire logic lst_ready,
  // Service request and address control.
  input wire logic svc_request,
  input wire logic [7:0] status_byte,
  input wire logic [4:0] pwrup_addr,
  input wire logic addr_wr,
  input wire logic [4:0] addr_in,
  output logic [4:0] bus_addr,
  output logic talker,
  output logic listener,
  output logic remote,
  // Clear and trigger.
  input wire logic zero_output_clear_mode,
  input wire logic trg_cmd,
  output logic dev_clear,
  output logic clear_zeroes_output_setting,
  output logic clear_keeps_output_setting,
  output logic trigger,
  // Serial receive and transmit characters.
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // Serial configuration and line hand-over.
  input wire logic cfg_wr,
  input wire logic [9:0] cfg_in,
  output logic [9:0] ser_cfg,
  output logic tx_enabled,
  output logic line_done,
  output logic [$clog2(LINE_DEPTH):0] line_len,
  input wire logic [$clog2(LINE_DEPTH)-1:0] line_rd_addr,
  output logic [7:0] line_rd_data
);
  localparam int LW = $clog2(LINE_DEPTH);
  generate
    if (LINE_DEPTH < 2) begin : g_bad
      $error("Bad line depth.");
    end
  endgenerate

  // ----------------
  // State record.
  // ----------------
  typedef struct packed {
    acc_state_type acc; // Acceptor state.
    src_state_type src; // Source state.
    tx_state_type tx; // Reply state.
    logic [7:0] dio; // Talker byte.
    logic dio_oe; // Data driven.
    logic dav; // Data valid.
    logic nrfd; // Not ready.
    logic ndac; // Not accepted.
    logic eoi; // End.
    logic srq; // Service request.
    logic src_done; // Byte sent.
    logic push; // FIFO push.
    logic [8:0] rx_byte; // Byte and end.
    logic talk; // Talker.
    logic listen; // Listener.
    logic poll; // Serial poll.
    logic remote; // Remote control.
    logic loaded; // Address loaded.
    logic [4:0] addr; // Bus address.
    logic clr; // Clear pulse.
    logic clr_zero; // Zeroing clear.
    logic clr_keep; // Keeping clear.
    logic trg; // Trigger pulse.
    logic [9:0] cfg; // Serial setup.
    logic tx_en; // Sending allowed.
    logic tx_valid; // Reply valid.
    logic [7:0] tx_data; // Reply byte.
    logic [LW:0] len; // Chars held.
    logic line_done; // Line handed.
    logic [LW:0] line_len; // Length handed.
  } state_type;

  state_type s_reg;
  state_type s_next;
  logic [7:0] line_mem [LINE_DEPTH]; // Serial input line buffer.
  logic [7:0] rd_data_reg; // Registered buffer read.
  logic fifo_ready; // Room in the listener FIFO.
  logic [7:0] cmd; // Byte on data lines.
  logic store; // Store received character.

  assign cmd = dio_in;
  // Printable characters are stored while there is room.
  assign store = rx_valid && rx_data >= CH_PRINT && s_reg.len != (LW+1)'(LINE_DEPTH);

  // ----------------
  // Listener byte FIFO.
  // ----------------
  byte_fifo #(.WIDTH(9), .DEPTH(4)) u_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_valid(s_reg.push),
    .in_data(s_reg.rx_byte),
    .in_ready(fifo_ready),
    .out_valid(lst_valid),
    .out_data(lst_data),
    .out_ready(lst_ready)
  );

  // ----------------
  // Next state.
  // ----------------
  // Fills the whole next record from the current one and the inputs.
  always_comb begin
    s_next = s_reg;
    s_next.src_done = 1'b0;
    s_next.push = 1'b0;
    s_next.clr = 1'b0;
    s_next.clr_zero = 1'b0;
    s_next.clr_keep = 1'b0;
    s_next.trg = trg_cmd;
    s_next.line_done = 1'b0;
    s_next.srq = svc_request;
    // Address takes the power-up value once, then command writes.
    if (!s_reg.loaded) begin
      s_next.addr = pwrup_addr;
      s_next.loaded = 1'b1;
    end else if (addr_wr) begin
      s_next.addr = addr_in;
    end
    if (cfg_wr) begin
      s_next.cfg = cfg_in;
    end
    // Acceptor handshake; a full FIFO holds off data bytes.
    unique case (s_reg.acc)
      acc_ready: begin
        s_next.nrfd = !atn_in && s_reg.listen && !fifo_ready;
        s_next.ndac = 1'b1;
        if (dav_in && !s_reg.nrfd && (atn_in || s_reg.listen)) begin
          s_next.nrfd = 1'b1;
          s_next.ndac = 1'b0;
          s_next.acc = acc_take;
          if (!atn_in) begin
            s_next.rx_byte = {eoi_in, cmd};
            s_next.push = 1'b1;
            s_next.remote = 1'b1;
          end else if (cmd == BASE_LISTEN + {3'h0, s_reg.addr}) begin
            s_next.listen = 1'b1;
            s_next.talk = 1'b0;
          end else if (cmd == BASE_TALK + {3'h0, s_reg.addr}) begin
            s_next.talk = 1'b1;
            s_next.listen = 1'b0;
          end else if (cmd[7:5] == 3'h2) begin
            s_next.talk = 1'b0;
          end else if (cmd == CMD_UNLISTEN) begin
            s_next.listen = 1'b0;
          end else if (cmd == CMD_POLL_ON) begin
            s_next.poll = 1'b1;
          end else if (cmd == CMD_POLL_OFF) begin
            s_next.poll = 1'b0;
          end else if (cmd == CMD_DEV_CLEAR || (cmd == CMD_SEL_CLEAR && s_reg.listen)) begin
            s_next.clr = 1'b1;
            s_next.clr_zero = zero_output_clear_mode;
            s_next.clr_keep = !zero_output_clear_mode;
          end else if (cmd == CMD_TRIGGER && s_reg.listen) begin
            s_next.trg = 1'b1;
          end else if (cmd == CMD_PP_CONFIG) begin
            s_next.acc = acc_take;
          end
        end
      end
      acc_take: begin
        if (!dav_in) begin
          s_next.ndac = 1'b1;
          s_next.acc = acc_wait;
        end
      end
      acc_wait: begin
        s_next.nrfd = 1'b0;
        s_next.acc = acc_ready;
      end
    endcase
    // Source handshake for talker data and the polled status byte.
    unique case (s_reg.src)
      src_idle: begin
        s_next.dav = 1'b0;
        s_next.dio_oe = 1'b0;
        s_next.eoi = 1'b0;
        // The cycle of the done pulse is skipped so the source can step on.
        if (s_reg.talk && !atn_in && !s_reg.src_done && (s_reg.poll || src_valid)) begin
          s_next.dio_oe = 1'b1;
          s_next.dio = src_data;
          s_next.eoi = src_end;
          if (s_reg.poll) begin
            s_next.dio = status_byte;
            s_next.dio[RQS_BIT] = s_reg.srq;
            s_next.eoi = 1'b0;
          end
          s_next.src = src_wait_rfd;
        end
      end
      src_wait_rfd: begin
        if (!nrfd_in) begin
          s_next.dav = 1'b1;
          s_next.src = src_wait_dac;
        end
      end
      src_wait_dac: begin
        if (!ndac_in) begin
          s_next.dav = 1'b0;
          s_next.src_done = !s_reg.poll;
          s_next.src = src_idle;
        end
      end
    endcase
    if (atn_in && s_reg.src != src_idle) begin
      s_next.src = src_idle;
      s_next.dav = 1'b0;
      s_next.dio_oe = 1'b0;
    end
    if (ifc_in) begin
      s_next.talk = 1'b0;
      s_next.listen = 1'b0;
      s_next.poll = 1'b0;
    end
    // Serial receive handling of special characters.
    if (rx_valid) begin
      if (rx_data == CH_CR || rx_data == CH_LF) begin
        s_next.line_done = 1'b1;
        s_next.line_len = s_reg.len;
        s_next.len = '0;
        s_next.remote = 1'b1;
      end else if (rx_data == CH_ESC) begin
        s_next.len = '0;
        s_next.tx = tx_cr;
      end else if (rx_data == CH_BS && s_reg.len != '0) begin
        s_next.len = s_reg.len - 1'b1;
      end else if (rx_data == CH_CAN) begin
        s_next.len = '0;
        s_next.tx = tx_idle;
        s_next.tx_valid = 1'b0;
      end else if (rx_data == CH_XON && s_reg.cfg[CFG_FLOW]) begin
        s_next.tx_en = 1'b1;
      end else if (rx_data == CH_XOFF && s_reg.cfg[CFG_FLOW]) begin
        s_next.tx_en = 1'b0;
      end else if (store) begin
        s_next.len = s_reg.len + 1'b1;
      end
    end
    // Reply sequence of carriage return then line feed.
    if (!(rx_valid && rx_data == CH_CAN)) begin
      unique case (s_reg.tx)
        tx_idle: begin
          s_next.tx_valid = 1'b0;
        end
        tx_cr, tx_lf: begin
          s_next.tx_valid = s_reg.tx_en;
          s_next.tx_data = s_reg.tx == tx_cr ? CH_CR : CH_LF;
          if (s_reg.tx_valid && tx_ready) begin
            s_next.tx = s_reg.tx == tx_cr ? tx_lf : tx_idle;
            s_next.tx_data = CH_LF;
            s_next.tx_valid = s_reg.tx == tx_cr && s_reg.tx_en;
          end
        end
      endcase
    end
  end

  // ----------------
  // State registers.
  // ----------------
  // Registers the record; zero is the idle state of every machine.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_reg <= '0;
      s_reg.addr <= DEF_BUS_ADDR;
      s_reg.cfg <= CFG_RESET;
      s_reg.tx_en <= 1'b1;
      s_reg.ndac <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Line buffer write in arrival order and registered read.
  always_ff @(posedge sys_clk) begin
    if (store) begin
      line_mem[s_reg.len[LW-1:0]] <= rx_data;
    end
    rd_data_reg <= line_mem[line_rd_addr];
  end

  // ----------------
  // Outputs.
  // ----------------
  assign dio_out = s_reg.dio;
  assign dio_oe = s_reg.dio_oe;
  assign dav_out = s_reg.dav;
  assign dav_oe = s_reg.dav;
  assign nrfd_out = s_reg.nrfd;
  assign nrfd_oe = s_reg.nrfd;
  assign ndac_out = s_reg.ndac;
  assign ndac_oe = s_reg.ndac;
  assign eoi_out = s_reg.eoi;
  assign eoi_oe = s_reg.eoi;
  assign srq_out = s_reg.srq;
  assign srq_oe = s_reg.srq;
  assign src_done = s_reg.src_done;
  assign bus_addr = s_reg.addr;
  assign talker = s_reg.talk;
  assign listener = s_reg.listen;
  assign remote = s_reg.remote;
  assign dev_clear = s_reg.clr;
  assign clear_zeroes_output_setting = s_reg.clr_zero;
  assign clear_keeps_output_setting = s_reg.clr_keep;
  assign trigger = s_reg.trg;
  assign tx_valid = s_reg.tx_valid;
  assign tx_data = s_reg.tx_data;
  assign ser_cfg = s_reg.cfg;
  assign tx_enabled = s_reg.tx_en;
  assign line_done = s_reg.line_done;
  assign line_len = s_reg.line_len;
  assign line_rd_data = rd_data_reg;
endmodule : instrument_bus_host_port

// ### instrument_bus_pkg.sv
// Purpose: Shared constants and types of the instrument bus host port.
// Assumes: Bus lines are seen in logical sense, high means asserted.
// Notes: Serial configuration is one packed word of named fields.
package instrument_bus_pkg;
  // ----------------
  // Bus addressing and command bytes.
  // ----------------
  localparam logic [4:0] DEF_BUS_ADDR = 5'h06; // Address loaded by reset.
  localparam logic [7:0] BASE_LISTEN = 8'h20; // Listen address group.
  localparam logic [7:0] BASE_TALK = 8'h40; // Talk address group.
  localparam logic [7:0] CMD_UNLISTEN = 8'h3F; // Unlisten.
  localparam logic [7:0] CMD_UNTALK = 8'h5F; // Untalk.
  localparam logic [7:0] CMD_SEL_CLEAR = 8'h04; // Selected device clear.
  localparam logic [7:0] CMD_PP_CONFIG = 8'h05; // Parallel poll configure.
  localparam logic [7:0] CMD_TRIGGER = 8'h08; // Group execute trigger.
  localparam logic [7:0] CMD_DEV_CLEAR = 8'h14; // Universal device clear.
  localparam logic [7:0] CMD_POLL_ON = 8'h18; // Serial poll enable.
  localparam logic [7:0] CMD_POLL_OFF = 8'h19; // Serial poll disable.
  localparam int RQS_BIT = 6; // Request service bit in status byte.
  // ----------------
  // Serial special characters.
  // ----------------
  localparam logic [7:0] CH_BS = 8'h08; // Backspace.
  localparam logic [7:0] CH_LF = 8'h0A; // Line feed.
  localparam logic [7:0] CH_CR = 8'h0D; // Carriage return.
  localparam logic [7:0] CH_XON = 8'h11; // Transmit on.
  localparam logic [7:0] CH_XOFF = 8'h13; // Transmit off.
  localparam logic [7:0] CH_CAN = 8'h18; // Cancel.
  localparam logic [7:0] CH_ESC = 8'h1B; // Escape.
  localparam logic [7:0] CH_PRINT = 8'h20; // First printable code.
  // ----------------
  // Serial configuration word layout.
  // ----------------
  localparam int CFG_BITS_LSB = 0; // Data bits, four bits wide.
  localparam int CFG_STOP_LSB = 4; // Stop bits, two bits wide.
  localparam int CFG_PAR_LSB = 6; // Parity, two bits, zero is none.
  localparam int CFG_PROMPT = 8; // Prompt enable.
  localparam int CFG_FLOW = 9; // Flow control enable.
  localparam logic [9:0] CFG_RESET = 10'h218; // Eight, one, none, flow on.
  // ----------------
  // State types.
  // ----------------
  typedef enum logic [1:0] {acc_ready, acc_take, acc_wait} acc_state_type;
  typedef enum logic [1:0] {src_idle, src_wait_rfd, src_wait_dac} src_state_type;
  typedef enum logic [1:0] {tx_idle, tx_cr, tx_lf} tx_state_type;
endpackage : instrument_bus_pkg

// ### host_port_checker_asserts.sv
// Purpose: Concurrent checks on the ports of the host port.
// Assumes: One clock domain; bound to the top module by the bench.
// Notes: Bus lines are in logical sense, high means asserted.
`timescale 1ns/1ps
module host_port_checker
  import instrument_bus_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Bus lines.
  input wire logic dio_oe,
  input wire logic dav_in,
  input wire logic dav_out,
  input wire logic nrfd_out,
  input wire logic ndac_in,
  input wire logic ndac_out,
  input wire logic atn_in,
  input wire logic svc_request,
  input wire logic srq_out,
  input wire logic src_done,
  input wire logic talker,
  input wire logic listener,
  // Clear.
  input wire logic zero_output_clear_mode,
  input wire logic dev_clear,
  input wire logic clear_zeroes_output_setting,
  input wire logic clear_keeps_output_setting,
  // Serial.
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic tx_enabled,
  input wire logic line_done
);
  // ----------------
  // Assertions.
  // ----------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // A taken byte is acknowledged on the next edge.
  a_acc_answer: assert property ((dav_in && !nrfd_out && ndac_out && (atn_in || listener))
    |=> (nrfd_out && !ndac_out)) else $error("byte not acknowledged");
  // Done follows an accepted byte.
  a_src_done_cause: assert property (src_done |-> $past(dav_out) && !$past(ndac_in))
    else $error("done without accepted byte");
  // Data valid needs driven data.
  a_dav_with_data: assert property (dav_out |-> dio_oe)
    else $error("valid without data");
  // Attention frees the data lines.
  a_atn_abort: assert property (atn_in |=> !dio_oe)
    else $error("data driven under attention");
  // Talker and listener exclude each other.
  a_role_excl: assert property (!(talker && listener))
    else $error("talker and listener");
  // The request line follows the condition.
  a_srq_follow: assert property ($past(resetn) |-> srq_out == $past(svc_request))
    else $error("request line wrong");
  // A clear shows exactly one kind, matching the mode.
  a_clear_pulse: assert property (dev_clear |->
    (clear_zeroes_output_setting != clear_keeps_output_setting)) else $error("clear kinds");
  a_clear_kind: assert property (
    (clear_zeroes_output_setting || clear_keeps_output_setting)
    |-> dev_clear && clear_zeroes_output_setting == zero_output_clear_mode)
    else $error("clear kind wrong");
  // A line ends only on a terminator.
  a_line_cause: assert property (line_done |-> $past(rx_valid) &&
    ($past(rx_data) == CH_CR || $past(rx_data) == CH_LF)) else $error("line without end");
  // A reply character holds until taken.
  a_tx_hold: assert property (tx_valid && !tx_ready && tx_enabled && !rx_valid
    |=> tx_valid && $stable(tx_data)) else $error("reply dropped");
  // A reply opens with a carriage return.
  a_reply_cr: assert property ($rose(tx_valid) |-> tx_data == CH_CR)
    else $error("reply not opened by return");
endmodule : host_port_checker

// ### host_ctrl_model.sv
// Purpose: Host controller model on the far side of the bus.
// Assumes: Logical sense; a released line reads 0 through its pull-up.
// Notes: Tasks are called by the bench; every wait is bounded.
`timescale 1ns/1ps
module host_ctrl_model (
  // Clock.
  input wire logic sys_clk,
  // Lines seen from the port.
  input wire logic [7:0] bus_dio,
  input wire logic dav_out,
  input wire logic nrfd_out,
  input wire logic ndac_out,
  input wire logic eoi_out,
  // Lines driven by the host.
  output logic [7:0] h_dio,
  output logic h_dav,
  output logic h_nrfd,
  output logic h_ndac,
  output logic h_eoi,
  output logic h_atn
);
  // Idle host holds not ready and not accepted, so the port must wait.
  initial begin
    h_dio = 8'h00;
    {h_dav, h_eoi, h_atn} = 3'h0;
    {h_nrfd, h_ndac} = 2'h3;
  end
  // Source one byte: present it, wait for ready, hold until accepted.
  task automatic send(input logic [7:0] b, input logic atn, input logic eoi);
    @(posedge sys_clk);
    h_atn <= atn;
    h_dio <= b;
    h_eoi <= eoi;
    for (int i = 0; i < 99 && nrfd_out !== 1'b0; i++) @(posedge sys_clk);
    @(posedge sys_clk);
    h_dav <= 1'b1;
    for (int i = 0; i < 99 && ndac_out !== 1'b0; i++) @(posedge sys_clk);
    h_dav <= 1'b0;
    h_dio <= 8'h00;
    h_eoi <= 1'b0;
    h_atn <= 1'b0;
  endtask : send
  // Accept one byte from the talker with the full three-wire cycle.
  task automatic take(output logic [7:0] b, output logic e);
    @(posedge sys_clk);
    h_nrfd <= 1'b0;
    for (int i = 0; i < 99 && dav_out !== 1'b1; i++) @(posedge sys_clk);
    b = bus_dio;
    e = eoi_out;
    h_nrfd <= 1'b1;
    h_ndac <= 1'b0;
    for (int i = 0; i < 99 && dav_out !== 1'b0; i++) @(posedge sys_clk);
    h_ndac <= 1'b1;
  endtask : take
endmodule : host_ctrl_model

// ### instrument_bus_host_port_tb.sv
// Purpose: Self-checking bench of the instrument bus host port.
// Assumes: Host model drives the bus; random values from seed 23.
// Notes: Line buffer shortened to eight characters.
`timescale 1ns/1ps
module instrument_bus_host_port_tb;
  import instrument_bus_pkg::*;
  // ----------------
  // Signals.
  // ----------------
  localparam int LD = 8; // Shortened line depth.
  localparam logic [4:0] ADR = DEF_BUS_ADDR; // Address written by command.
  logic sys_clk, resetn, src_valid, src_end, lst_ready, svc_request, addr_wr, trg_cmd;
  logic zero_output_clear_mode, rx_valid, tx_ready, cfg_wr, e, dio_oe, dav_out, dav_oe;
  logic nrfd_out, nrfd_oe, ndac_out, ndac_oe, eoi_out, eoi_oe, srq_out, srq_oe, src_done;
  logic lst_valid, talker, listener, remote, dev_clear, clear_zeroes_output_setting;
  logic clear_keeps_output_setting, trigger, tx_valid, tx_enabled, line_done;
  logic h_dav, h_nrfd, h_ndac, h_eoi, h_atn;
  logic [7:0] src_data, status_byte, rx_data, dio_out, tx_data, line_rd_data, h_dio, bus_dio;
  logic [7:0] b, rb;
  logic [4:0] pwrup_addr, addr_in, bus_addr;
  logic [9:0] cfg_in, ser_cfg;
  logic [8:0] lst_data;
  logic [3:0] line_len;
  logic [2:0] line_rd_addr;
  logic [8:0] exp_q[$]; // Expected listener words.
  logic [7:0] tx_q[$], line[$]; // Replies seen; expected line contents.
  int fails, checks, cyc, cnt[6], n0[6];
  // Wired bus: a released line reads as not asserted.
  assign bus_dio = (dio_oe ? dio_out : 8'h00) | h_dio;
  // ----------------
  // Instances.
  // ----------------
  instrument_bus_host_port #(.LINE_DEPTH(LD)) u_dut (.dio_in(bus_dio), .dav_in(h_dav),
    .nrfd_in(h_nrfd), .ndac_in(h_ndac), .eoi_in(h_eoi | eoi_out), .atn_in(h_atn),
    .ifc_in(1'b0), .*);
  host_ctrl_model u_host (.*);
  // Clock of 4 ns.
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Count pulses, drain the FIFO against expectations, collect replies, guard time.
  always @(posedge sys_clk) begin
    cnt[0] += int'(dev_clear);
    cnt[1] += int'(clear_zeroes_output_setting);
    cnt[2] += int'(clear_keeps_output_setting);
    cnt[3] += int'(trigger);
    cnt[4] += int'(line_done);
    cnt[5] += int'(src_done);
    if (lst_valid && lst_ready) chk("lst_data", 16'(lst_data), 16'(exp_q.pop_front()));
    if (tx_valid && tx_ready) tx_q.push_back(tx_data);
    cyc++;
    if (cyc > 20000) begin
      fails++;
      final_report();
    end
  end
  // ----------------
  // Tasks.
  // ----------------
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] x);
    checks++;
    if (s !== x) begin
      fails++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  // Send one serial character and update the expected line.
  task automatic put(input logic [7:0] c);
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_data <= c;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    if (c == CH_BS && line.size() > 0) void'(line.pop_back());
    else if (c == CH_ESC || c == CH_CAN) line.delete();
    else if (c >= CH_PRINT && line.size() < LD) line.push_back(c);
  endtask : put
  // Terminate a line and compare length and contents.
  task automatic end_line(input logic [7:0] t);
    int n;
    n = cnt[4];
    put(t);
    tick(2);
    chk("line_done", 16'(cnt[4] - n), 16'h0001);
    chk("line_len", 16'(line_len), 16'(line.size()));
    foreach (line[i]) begin
      line_rd_addr <= 3'(i);
      tick(2);
      chk("line_byte", 16'(line_rd_data), 16'(line[i]));
    end
    line.delete();
  endtask : end_line
  task automatic cmd(input logic [7:0] c);
    u_host.send(c, 1'b1, 1'b0);
    tick(2);
  endtask : cmd
  // ----------------
  // Main sequence.
  // ----------------
  initial begin
    {resetn, src_valid, src_end, lst_ready, svc_request, addr_wr, trg_cmd} = 7'h00;
    {zero_output_clear_mode, rx_valid, tx_ready, cfg_wr} = 4'h0;
    {src_data, status_byte, rx_data} = 24'h0000_00;
    {pwrup_addr, addr_in, line_rd_addr} = 13'h1600;
    cfg_in = CFG_RESET;
    {fails, checks, cyc} = {32'h0, 32'h0, 32'h0};
    cnt = '{default: 0};
    void'($urandom(23));
    tick(20);
    chk("addr_rst", 16'(bus_addr), 16'(DEF_BUS_ADDR));
    resetn <= 1'b1;
    tick(3);
    chk("addr_pwr", 16'(bus_addr), 16'h0016);
    chk("ser_cfg", 16'(ser_cfg), 16'(CFG_RESET));
    chk("remote0", 16'(remote), 16'h0000);
    addr_wr <= 1'b1;
    addr_in <= ADR;
    tick(1);
    addr_wr <= 1'b0;
    tick(2);
    chk("addr_cmd", 16'(bus_addr), 16'(ADR));
    cmd(BASE_LISTEN | 8'(ADR));
    chk("listen", 16'(listener), 16'h0001);
    // Fill the FIFO with the drain stalled, then release it.
    for (int i = 0; i < 5; i++) begin
      b = 8'($urandom);
      exp_q.push_back({1'(i == 4), b});
      fork
        u_host.send(b, 1'b0, 1'(i == 4));
        if (i == 4) begin
          tick(30);
          chk("nrfd_full", 16'(nrfd_out), 16'h0001);
          lst_ready <= 1'b1;
        end
      join
    end
    tick(10);
    chk("fifo_left", 16'(exp_q.size()), 16'h0000);
    chk("remote1", 16'(remote), 16'h0001);
    // Clears in both modes, bus and command triggers, ignored poll configure.
    for (int m = 0; m < 2; m++) begin
      zero_output_clear_mode <= 1'(m);
      n0 = cnt;
      cmd(CMD_DEV_CLEAR);
      cmd(CMD_SEL_CLEAR);
      cmd(CMD_TRIGGER);
      cmd(CMD_PP_CONFIG);
      trg_cmd <= 1'b1;
      tick(1);
      trg_cmd <= 1'b0;
      tick(3);
      chk("clear", 16'(cnt[0] - n0[0]), 16'h0002);
      chk("zeroes", 16'(cnt[1] - n0[1]), 16'(2 * m));
      chk("keeps", 16'(cnt[2] - n0[2]), 16'(2 - 2 * m));
      chk("trigger", 16'(cnt[3] - n0[3]), 16'h0002);
    end
    chk("pp_ignored", 16'(listener), 16'h0001);
    cmd(BASE_TALK | 8'(ADR));
    chk("talk_swap", 16'({talker, listener}), 16'h0002);
    // Three bytes back to back, the last with END.
    n0 = cnt;
    src_valid <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      src_data <= b;
      src_end <= 1'(i == 2);
      u_host.take(rb, e);
      chk("talk_byte", 16'({e, rb}), 16'({1'(i == 2), b}));
    end
    src_valid <= 1'b0;
    tick(2);
    chk("src_done", 16'(cnt[5] - n0[5]), 16'h0003);
    cmd(BASE_LISTEN | 8'(ADR));
    chk("mla_drop", 16'({talker, listener}), 16'h0001);
    cmd(CMD_UNLISTEN);
    chk("unl", 16'(listener), 16'h0000);
    u_host.send(8'h55, 1'b0, 1'b0);
    chk("refused", 16'(lst_valid), 16'h0000);
    // Service request and serial poll.
    status_byte <= 8'($urandom) & 8'hBF;
    svc_request <= 1'b1;
    tick(3);
    chk("srq", 16'(srq_out), 16'h0001);
    cmd(CMD_POLL_ON);
    cmd(BASE_TALK | 8'(ADR));
    u_host.take(rb, e);
    chk("poll_byte", 16'(rb), 16'(status_byte | 8'h40));
    cmd(CMD_POLL_OFF);
    cmd(BASE_TALK | 8'(ADR + 5'h01));
    chk("ota", 16'(talker), 16'h0000);
    cmd(BASE_TALK | 8'(ADR));
    cmd(CMD_UNTALK);
    chk("unt", 16'(talker), 16'h0000);
    // Serial lines: random text with backspace, then an overlong line.
    tx_ready <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      repeat (k ? 10 : 3 + $urandom % 4) put(8'h21 + 8'($urandom % 94));
      if (k == 0) put(CH_BS);
      end_line(k ? CH_LF : CH_CR);
    end
    // Escape with the receiver of the reply stalled.
    tx_ready <= 1'b0;
    put(8'h41);
    put(CH_ESC);
    tick(4);
    chk("tx_hold", 16'({tx_valid, tx_data}), 16'h010D);
    tx_ready <= 1'b1;
    tick(4);
    chk("tx_reply", 16'({tx_q[0], tx_q[1]}), 16'h0D0A);
    end_line(CH_LF);
    put(8'h42);
    put(CH_CAN);
    end_line(CH_CR);
    // Flow control characters, then with flow control switched off.
    put(CH_XOFF);
    tick(2);
    chk("xoff", 16'(tx_enabled), 16'h0000);
    put(CH_XON);
    tick(2);
    chk("xon", 16'(tx_enabled), 16'h0001);
    cfg_wr <= 1'b1;
    cfg_in <= CFG_RESET & ~10'h200;
    tick(1);
    cfg_wr <= 1'b0;
    put(CH_XOFF);
    tick(2);
    chk("xoff_off", 16'(tx_enabled), 16'h0001);
    chk("cfg_wr", 16'(ser_cfg), 16'(CFG_RESET & ~10'h200));
    final_report();
  end
endmodule : instrument_bus_host_port_tb

bind instrument_bus_host_port host_port_checker u_chk (.*);
